// [ussfw_top.sv]
// Purpose: UART channel with sample count, global status and queue windows
// Assumes: APB3 master, 8 data bits, one stop bit
// Notes:   One wait state on every APB access
// Overview of operation
// - Sample code n gives 16 minus n samples, 4 samples for codes above 12
// - Sample register at 16h, upper nibble zero
// - Special bit 7 shows transmit count instead
// - Status bit 0: receive queue not empty
// - Status bit 1: character lost, queue full
// - Status bits 2,3: parity and framing errors
// - Status bit 4: break on receive line
// - Status bit 5: transmit queue empty
// - Status bit 6: transmit shifter empty
// - Status bit 7: errored character queued
// - Reads 100h-17Fh return receive data
// - Writes 100h-17Fh load transmit queue
// - Reads 180h-1FFh return line-state entry
module ussfw_top (
	// Clock and reset
	input  wire logic                           MCLK,
	input  wire logic                           RST_B,
	// APB slave
	input  wire logic                           PSEL,
	input  wire logic                           PENABLE,
	input  wire logic                           PWRITE,
	input  wire logic [ussfw_pkg::ADDR_W-1:0]   PADDR,
	input  wire logic [ussfw_pkg::DATA_W-1:0]   PWDATA,
	output      logic [ussfw_pkg::DATA_W-1:0]   PRDATA,
	output      logic                           PREADY,
	output      logic                           PSLVERR,
	// Serial line
	input  wire logic                           RXD,
	output      logic                           TXD
);
	// ==========================================================
	// Helpers
	function automatic logic in_range(input logic [9:0] idx,
		input logic [9:0] lo, input logic [9:0] hi);
		in_range = (idx >= lo) && (idx <= hi);
	endfunction

	function automatic logic [4:0] samples_per_bit(input logic [3:0] code);
		if (code > ussfw_pkg::SAMPLE_MAX_CODE) begin
			samples_per_bit = ussfw_pkg::SAMPLES_MIN;
		end else begin
			samples_per_bit = 5'(ussfw_pkg::SAMPLES_BASE - {1'b0, code});
		end
	endfunction

	// ==========================================================
	// Registers
	logic [7:0]                       special_function_select_reg;
	logic [1:0]                       line_fmt_reg;
	logic [3:0]                       sample_code_reg;
	logic [7:0]                       global_line_state_reg;
	logic                             ovr_st_reg;
	logic                             par_st_reg;
	logic                             frm_st_reg;
	logic                             brk_st_reg;
	logic [ussfw_pkg::CNT_W:0]        rx_err_cnt_reg;
	logic [ussfw_pkg::DATA_W-1:0]     prdata_reg;
	logic                             pready_reg;
	logic                             pslverr_reg;
	logic                             rxd_s1_reg;
	logic                             rxd_s2_reg;
	logic                             rxd_s3_reg;
	logic                             rx_line_reg;
	logic [15:0]                      div_cnt_reg;
	ussfw_pkg::ussfw_rx_state_t       rx_state_reg;
	logic [4:0]                       rx_cnt_reg;
	logic [2:0]                       rx_bit_reg;
	logic [7:0]                       rx_shift_reg;
	logic                             rx_perr_reg;
	ussfw_pkg::ussfw_tx_state_t       tx_state_reg;
	logic [4:0]                       tx_cnt_reg;
	logic [2:0]                       tx_bit_reg;
	logic [7:0]                       tx_shift_reg;
	logic                             tx_par_reg;
	logic                             txd_reg;

	// ==========================================================
	// Bus decode
	wire [9:0]  idx         = PADDR[11:2];
	wire        hit_fmt     = (idx == ussfw_pkg::IDX_LINE_FMT);
	wire        hit_special = (idx == ussfw_pkg::IDX_SPECIAL);
	wire        hit_sample  = (idx == ussfw_pkg::IDX_SAMPLE);
	wire        hit_global  = (idx == ussfw_pkg::IDX_GLOBAL);
	wire        hit_rxwin   = in_range(idx, ussfw_pkg::IDX_RXWIN_LO,
		ussfw_pkg::IDX_RXWIN_HI);
	wire        hit_lswin   = in_range(idx, ussfw_pkg::IDX_LSWIN_LO,
		ussfw_pkg::IDX_LSWIN_HI);
	wire        mapped      = hit_fmt | hit_special | hit_sample
		| hit_global | hit_rxwin | hit_lswin;
	wire        access      = PSEL & PENABLE;
	wire        pready_next = access & ~pready_reg;
	wire        done        = access & pready_reg;
	wire        wr_done     = done & PWRITE;
	wire        rd_done     = done & ~PWRITE;
	wire        txcnt_sel   =
		special_function_select_reg[ussfw_pkg::SPECIAL_TXCNT_BIT];

	// ==========================================================
	// Queues
	wire [15:0]                 rx_head;
	wire [ussfw_pkg::CNT_W:0]   rx_count;
	wire                        rx_empty;
	wire                        rx_full;
	wire [7:0]                  tx_head;
	wire [ussfw_pkg::CNT_W:0]   tx_count;
	wire                        tx_empty;
	wire                        tx_full;
	wire                        rx_pop  = rd_done & hit_rxwin & ~rx_empty;
	wire                        tx_push = wr_done & hit_rxwin & ~tx_full;
	wire                        tx_pop;
	wire                        rx_push;
	wire [7:0]                  rx_entry;

	ussfw_fifo #(.W(16)) u_rx_fifo (
		.clk       (MCLK),
		.rst_b     (RST_B),
		.push      (rx_push & ~rx_full),
		.push_data ({rx_entry, rx_shift_reg}),
		.pop       (rx_pop),
		.head      (rx_head),
		.count     (rx_count),
		.empty     (rx_empty),
		.full      (rx_full)
	);

	ussfw_fifo #(.W(8)) u_tx_fifo (
		.clk       (MCLK),
		.rst_b     (RST_B),
		.push      (tx_push),
		.push_data (PWDATA[7:0]),
		.pop       (tx_pop),
		.head      (tx_head),
		.count     (tx_count),
		.empty     (tx_empty),
		.full      (tx_full)
	);

	// ==========================================================
	// Read mux
	wire [7:0] sample_view = txcnt_sel ? 8'(tx_count)
		: {4'h0, sample_code_reg};
	wire [7:0] rxwin_view  = rx_empty ? 8'h00 : rx_head[7:0];
	wire [7:0] lswin_view  = rx_empty ? 8'h00 : rx_head[15:8];
	wire [7:0] rd_byte     =
		hit_fmt     ? {6'h00, line_fmt_reg} :
		hit_special ? special_function_select_reg :
		hit_sample  ? sample_view :
		hit_global  ? global_line_state_reg :
		hit_rxwin   ? rxwin_view :
		hit_lswin   ? lswin_view : 8'h00;

	// ==========================================================
	// APB answer
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			pready_reg  <= 1'b0;
			prdata_reg  <= '0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= pready_next;
			if (pready_next) begin
				prdata_reg  <= PWRITE ? '0 : {24'h000000, rd_byte};
				pslverr_reg <= ~mapped;
			end
		end
	end

	assign PRDATA  = prdata_reg;
	assign PREADY  = pready_reg;
	assign PSLVERR = pslverr_reg;

	// ==========================================================
	// Control registers
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			special_function_select_reg <= ussfw_pkg::SPECIAL_RST;
			line_fmt_reg                <= ussfw_pkg::FMT_RST;
			sample_code_reg             <= ussfw_pkg::SAMPLE_RST;
		end else if (wr_done) begin
			if (hit_special) begin
				special_function_select_reg <= PWDATA[7:0];
			end
			if (hit_fmt) begin
				line_fmt_reg <= PWDATA[1:0];
			end
			if (hit_sample && !txcnt_sel) begin
				sample_code_reg <= PWDATA[3:0];
			end
		end
	end

	wire [4:0] n_samp = samples_per_bit(sample_code_reg);
	wire [4:0] n_last = n_samp - 5'h01;
	wire [4:0] n_half = {1'b0, n_samp[4:1]};

	// ==========================================================
	// Sample tick and input synchroniser
	wire tick = (div_cnt_reg == ussfw_pkg::SAMPLE_DIV - 16'h0001);

	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			div_cnt_reg <= '0;
			rxd_s1_reg  <= 1'b1;
			rxd_s2_reg  <= 1'b1;
			rxd_s3_reg  <= 1'b1;
			rx_line_reg <= 1'b1;
		end else begin
			div_cnt_reg <= tick ? 16'h0000 : div_cnt_reg + 16'h0001;
			rxd_s1_reg  <= RXD;
			rxd_s2_reg  <= rxd_s1_reg;
			rxd_s3_reg  <= rxd_s2_reg;
			if (rxd_s2_reg == rxd_s3_reg) begin
				rx_line_reg <= rxd_s3_reg;
			end
		end
	end

	// ==========================================================
	// Receiver
	wire rx_end  = tick & (rx_cnt_reg == n_last);
	wire rx_brk  = ~rx_line_reg & (rx_shift_reg == 8'h00);
	wire rx_frm  = ~rx_line_reg & ~rx_brk;
	wire rx_err  = rx_perr_reg | rx_frm | rx_brk;
	assign rx_push = (rx_state_reg == ussfw_pkg::RX_STOP) & rx_end;
	assign rx_entry = {rx_err, 2'b00, rx_brk, rx_frm, rx_perr_reg, 2'b00};

	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			rx_state_reg <= ussfw_pkg::RX_IDLE;
			rx_cnt_reg   <= '0;
			rx_bit_reg   <= '0;
			rx_shift_reg <= '0;
			rx_perr_reg  <= 1'b0;
		end else begin
			case (rx_state_reg)
			ussfw_pkg::RX_IDLE: begin
				rx_cnt_reg  <= '0;
				rx_perr_reg <= 1'b0;
				if (!rx_line_reg) begin
					rx_state_reg <= ussfw_pkg::RX_START;
				end
			end
			ussfw_pkg::RX_START: begin
				if (tick && rx_cnt_reg == n_half) begin
					rx_cnt_reg   <= '0;
					rx_bit_reg   <= '0;
					rx_state_reg <= rx_line_reg ? ussfw_pkg::RX_IDLE
						: ussfw_pkg::RX_DATA;
				end else if (tick) begin
					rx_cnt_reg <= rx_cnt_reg + 5'h01;
				end
			end
			ussfw_pkg::RX_DATA: begin
				if (rx_end) begin
					rx_cnt_reg   <= '0;
					rx_shift_reg <= {rx_line_reg, rx_shift_reg[7:1]};
					rx_bit_reg   <= rx_bit_reg + 3'h1;
					if (rx_bit_reg == 3'h7) begin
						rx_state_reg <= line_fmt_reg[ussfw_pkg::FMT_PAR_EN]
							? ussfw_pkg::RX_PAR : ussfw_pkg::RX_STOP;
					end
				end else if (tick) begin
					rx_cnt_reg <= rx_cnt_reg + 5'h01;
				end
			end
			ussfw_pkg::RX_PAR: begin
				if (rx_end) begin
					rx_cnt_reg   <= '0;
					rx_perr_reg  <= ^{rx_shift_reg, rx_line_reg,
						line_fmt_reg[ussfw_pkg::FMT_PAR_ODD]};
					rx_state_reg <= ussfw_pkg::RX_STOP;
				end else if (tick) begin
					rx_cnt_reg <= rx_cnt_reg + 5'h01;
				end
			end
			ussfw_pkg::RX_STOP: begin
				if (rx_end) begin
					rx_state_reg <= ussfw_pkg::RX_HOLD;
				end else if (tick) begin
					rx_cnt_reg <= rx_cnt_reg + 5'h01;
				end
			end
			ussfw_pkg::RX_HOLD: begin
				if (rx_line_reg) begin
					rx_state_reg <= ussfw_pkg::RX_IDLE;
				end
			end
			default: rx_state_reg <= ussfw_pkg::RX_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Transmitter
	wire tx_end = tick & (tx_cnt_reg == n_last);
	assign tx_pop = (tx_state_reg == ussfw_pkg::TX_IDLE) & ~tx_empty;

	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			tx_state_reg <= ussfw_pkg::TX_IDLE;
			tx_cnt_reg   <= '0;
			tx_bit_reg   <= '0;
			tx_shift_reg <= '0;
			tx_par_reg   <= 1'b0;
			txd_reg      <= 1'b1;
		end else begin
			if (tx_end || tx_state_reg == ussfw_pkg::TX_IDLE) begin
				tx_cnt_reg <= '0;
			end else if (tick) begin
				tx_cnt_reg <= tx_cnt_reg + 5'h01;
			end
			case (tx_state_reg)
			ussfw_pkg::TX_IDLE: begin
				if (tx_pop) begin
					tx_shift_reg <= tx_head;
					tx_par_reg   <= ^{tx_head,
						line_fmt_reg[ussfw_pkg::FMT_PAR_ODD]};
					txd_reg      <= 1'b0;
					tx_state_reg <= ussfw_pkg::TX_START;
				end
			end
			ussfw_pkg::TX_START: begin
				if (tx_end) begin
					txd_reg      <= tx_shift_reg[0];
					tx_bit_reg   <= '0;
					tx_state_reg <= ussfw_pkg::TX_DATA;
				end
			end
			ussfw_pkg::TX_DATA: begin
				if (tx_end && tx_bit_reg == 3'h7) begin
					if (line_fmt_reg[ussfw_pkg::FMT_PAR_EN]) begin
						txd_reg      <= tx_par_reg;
						tx_state_reg <= ussfw_pkg::TX_PAR;
					end else begin
						txd_reg      <= 1'b1;
						tx_state_reg <= ussfw_pkg::TX_STOP;
					end
				end else if (tx_end) begin
					txd_reg      <= tx_shift_reg[1];
					tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
					tx_bit_reg   <= tx_bit_reg + 3'h1;
				end
			end
			ussfw_pkg::TX_PAR: begin
				if (tx_end) begin
					txd_reg      <= 1'b1;
					tx_state_reg <= ussfw_pkg::TX_STOP;
				end
			end
			ussfw_pkg::TX_STOP: begin
				if (tx_end) begin
					tx_state_reg <= ussfw_pkg::TX_IDLE;
				end
			end
			default: tx_state_reg <= ussfw_pkg::TX_IDLE;
			endcase
		end
	end

	assign TXD = txd_reg;

	// ==========================================================
	// Global line state
	wire gs_clr  = rd_done & hit_global;
	wire push_ok = rx_push & ~rx_full;
	wire pop_err = rx_pop & rx_head[8 + ussfw_pkg::GS_RX_ERR];
	wire [7:0] gs_next;

	assign gs_next[ussfw_pkg::GS_RX_AVAIL] = ~rx_empty;
	assign gs_next[ussfw_pkg::GS_OVERRUN]  = ovr_st_reg;
	assign gs_next[ussfw_pkg::GS_PARITY]   = par_st_reg;
	assign gs_next[ussfw_pkg::GS_FRAME]    = frm_st_reg;
	assign gs_next[ussfw_pkg::GS_BREAK]    = brk_st_reg;
	assign gs_next[ussfw_pkg::GS_TX_EMPTY] = tx_empty;
	assign gs_next[ussfw_pkg::GS_TX_DONE]  = tx_empty
		& (tx_state_reg == ussfw_pkg::TX_IDLE);
	assign gs_next[ussfw_pkg::GS_RX_ERR]   = (rx_err_cnt_reg != '0);

	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			global_line_state_reg <= ussfw_pkg::GLOBAL_RST;
			ovr_st_reg            <= 1'b0;
			par_st_reg            <= 1'b0;
			frm_st_reg            <= 1'b0;
			brk_st_reg            <= 1'b0;
			rx_err_cnt_reg        <= '0;
		end else begin
			global_line_state_reg <= gs_next;
			ovr_st_reg <= (rx_push & rx_full) | (ovr_st_reg & ~gs_clr);
			par_st_reg <= (push_ok & rx_perr_reg) | (par_st_reg & ~gs_clr);
			frm_st_reg <= (push_ok & rx_frm) | (frm_st_reg & ~gs_clr);
			brk_st_reg <= (push_ok & rx_brk) | (brk_st_reg & ~gs_clr);
			rx_err_cnt_reg <= rx_err_cnt_reg
				+ (ussfw_pkg::CNT_W+1)'(push_ok & rx_err)
				- (ussfw_pkg::CNT_W+1)'(pop_err);
		end
	end

endmodule

// [ussfw_pkg.sv]
// Purpose: Shared constants and types for the UART sample/status block
// Assumes: APB byte address is four times the register index
// Notes:   One channel, 8 data bits, one stop bit, optional parity
package ussfw_pkg;

	// ==========================================================
	// Bus geometry
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	// ==========================================================
	// Register indices (byte address = index * 4)
	localparam logic [9:0] IDX_LINE_FMT = 10'h003;
	localparam logic [9:0] IDX_SPECIAL  = 10'h007;
	localparam logic [9:0] IDX_SAMPLE   = 10'h016;
	localparam logic [9:0] IDX_GLOBAL   = 10'h017;
	localparam logic [9:0] IDX_RXWIN_LO = 10'h100;
	localparam logic [9:0] IDX_RXWIN_HI = 10'h17F;
	localparam logic [9:0] IDX_LSWIN_LO = 10'h180;
	localparam logic [9:0] IDX_LSWIN_HI = 10'h1FF;

	// ==========================================================
	// Reset values
	localparam logic [3:0] SAMPLE_RST  = 4'h0;
	localparam logic [7:0] SPECIAL_RST = 8'h00;
	localparam logic [1:0] FMT_RST     = 2'h0;
	localparam logic [7:0] GLOBAL_RST  = 8'h00;

	// ==========================================================
	// Field positions
	localparam int unsigned SPECIAL_TXCNT_BIT = 7;
	localparam int unsigned FMT_PAR_EN        = 0;
	localparam int unsigned FMT_PAR_ODD       = 1;
	localparam int unsigned GS_RX_AVAIL       = 0;
	localparam int unsigned GS_OVERRUN        = 1;
	localparam int unsigned GS_PARITY         = 2;
	localparam int unsigned GS_FRAME          = 3;
	localparam int unsigned GS_BREAK          = 4;
	localparam int unsigned GS_TX_EMPTY       = 5;
	localparam int unsigned GS_TX_DONE        = 6;
	localparam int unsigned GS_RX_ERR         = 7;

	// ==========================================================
	// Sample code decoding
	localparam logic [3:0] SAMPLE_MAX_CODE = 4'hC;
	localparam logic [4:0] SAMPLES_BASE    = 5'h10;
	localparam logic [4:0] SAMPLES_MIN     = 5'h04;

	// ==========================================================
	// Queues and timing
	localparam int unsigned FIFO_DEPTH = 64;
	localparam int unsigned CNT_W      = 7;
	localparam logic [15:0] SAMPLE_DIV = 16'h0044;

	// ==========================================================
	// State types
	typedef enum logic [2:0] {
		RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_HOLD
	} ussfw_rx_state_t;

	typedef enum logic [2:0] {
		TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
	} ussfw_tx_state_t;

endpackage

// [ussfw_fifo.sv]
// Purpose: Synchronous first-word-fall-through queue
// Assumes: Caller never pushes when full nor pops when empty
// Notes:   Count is one bit wider than the pointers
module ussfw_fifo #(
	parameter int unsigned W = 8
) (
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst_b,
	// Write side
	input  wire logic                          push,
	input  wire logic [W-1:0]                  push_data,
	// Read side
	input  wire logic                          pop,
	output      logic [W-1:0]                  head,
	// Fill state
	output      logic [ussfw_pkg::CNT_W:0]     count,
	output      logic                          empty,
	output      logic                          full
);
	// ==========================================================
	// Storage and pointers
	logic [W-1:0]                  mem [ussfw_pkg::FIFO_DEPTH];
	logic [ussfw_pkg::CNT_W-1:0]   wr_ptr_reg;
	logic [ussfw_pkg::CNT_W-1:0]   rd_ptr_reg;
	logic [ussfw_pkg::CNT_W:0]     count_reg;
	wire                           do_push;
	wire                           do_pop;

	assign do_push = push & ~full;
	assign do_pop  = pop & ~empty;
	assign head    = mem[rd_ptr_reg[ussfw_pkg::CNT_W-2:0]];
	assign count   = count_reg;
	assign empty   = (count_reg == '0);
	assign full    = (count_reg == (ussfw_pkg::CNT_W+1)'(ussfw_pkg::FIFO_DEPTH));

	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[wr_ptr_reg[ussfw_pkg::CNT_W-2:0]] <= push_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + ussfw_pkg::CNT_W'(do_push);
			rd_ptr_reg <= rd_ptr_reg + ussfw_pkg::CNT_W'(do_pop);
			count_reg  <= count_reg + (ussfw_pkg::CNT_W+1)'(do_push)
				- (ussfw_pkg::CNT_W+1)'(do_pop);
		end
	end

endmodule

// [ussfw_props.sv]
// Purpose: Port checker for the UART sample/status block
// Assumes: APB3 master, one wait state on every access
// Notes:   Shadows special and sample registers from bus writes
module ussfw_checker (
	// Clock and reset
	input wire logic        MCLK,
	input wire logic        RST_B,
	// APB
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	// Serial line
	input wire logic        RXD,
	input wire logic        TXD
);
	// ==========================================================
	// Bus shadows
	wire logic       done = PSEL && PENABLE && PREADY;
	wire logic       rd   = done && !PWRITE;
	wire logic [9:0] idx  = PADDR[11:2];
	wire logic       rxw  = idx >= ussfw_pkg::IDX_RXWIN_LO
		&& idx <= ussfw_pkg::IDX_RXWIN_HI;
	wire logic       lsw  = idx >= ussfw_pkg::IDX_LSWIN_LO
		&& idx <= ussfw_pkg::IDX_LSWIN_HI;
	logic       spec_reg;
	logic [3:0] samp_reg;
	logic       tx_used_reg;
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			spec_reg    <= 1'b0;
			samp_reg    <= 4'h0;
			tx_used_reg <= 1'b0;
		end else if (done && PWRITE) begin
			if (idx == ussfw_pkg::IDX_SPECIAL)
				spec_reg <= PWDATA[7];
			if (idx == ussfw_pkg::IDX_SAMPLE && !spec_reg)
				samp_reg <= PWDATA[3:0];
			if (rxw)
				tx_used_reg <= 1'b1;
		end
	end
	// ==========================================================
	// Assertions
	default clocking dc @(posedge MCLK);
	endclocking
	default disable iff (!RST_B);
	sequence setup_then_access;
		PSEL && !PENABLE ##1 PSEL && PENABLE;
	endsequence
	sequence one_wait_answer;
		!PREADY ##1 PREADY ##1 !PREADY;
	endsequence
	wait_state_a: assert property (setup_then_access |-> one_wait_answer)
		else $error("answer not after one wait state");
	ready_framed_a: assert property (PREADY |-> PSEL && PENABLE)
		else $error("ready outside access phase");
	error_gap_a: assert property (done && idx > ussfw_pkg::IDX_GLOBAL
		&& idx < ussfw_pkg::IDX_RXWIN_LO |-> PSLVERR)
		else $error("unmapped access not refused");
	sample_readback_a: assert property (
		rd && idx == ussfw_pkg::IDX_SAMPLE && !spec_reg
		|-> PRDATA == {28'h0, samp_reg})
		else $error("sample register readback wrong");
	tx_count_a: assert property (
		rd && idx == ussfw_pkg::IDX_SAMPLE && spec_reg
		|-> PRDATA <= 32'h40)
		else $error("transmit count out of range");
	window_ok_a: assert property (done && (rxw || lsw) |-> !PSLVERR)
		else $error("window access refused");
	entry_form_a: assert property (rd && lsw |-> PRDATA[31:8] == 24'h0
		&& PRDATA[7] == |PRDATA[4:2] && !(PRDATA[4] && PRDATA[3])
		&& PRDATA[6:5] == 2'h0 && PRDATA[1:0] == 2'h0)
		else $error("line-state entry malformed");
	error_needs_data_a: assert property (
		rd && idx == ussfw_pkg::IDX_GLOBAL |-> !PRDATA[7] || PRDATA[0])
		else $error("error flag without queued data");
	tx_idle_a: assert property (!tx_used_reg |-> TXD)
		else $error("line left idle without a write");
endmodule

bind ussfw_top ussfw_checker chk_u (.MCLK(MCLK), .RST_B(RST_B),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
	.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .RXD(RXD), .TXD(TXD));

// [ussfw_remote.sv]
// Purpose: Remote serial device beside the UART sample/status block
// Assumes: 8 data bits LSB first, one stop bit, idle high
// Notes:   Sends frames on request and keeps each received byte whose stop bit is high
module ussfw_remote #(
	parameter int BIT_CLKS = 272
) (
	// Clock
	input  wire logic MCLK,
	// Serial line
	input  wire logic TXD,
	output      logic RXD
);
	logic [7:0] got_q[$];
	logic [7:0] shift_reg;
	initial RXD = 1'b1;
	task automatic drive(input logic v);
		RXD <= v;
		repeat (BIT_CLKS) @(posedge MCLK);
	endtask
	// Frame out, break held low one bit more
	task automatic send(input logic [7:0] d, input logic par,
		input logic flip, input logic stop);
		drive(1'b0);
		for (int i = 0; i < 8; i++)
			drive(d[i]);
		if (par)
			drive(^d ^ flip);
		drive(stop);
		if (!stop && d == 8'h00)
			drive(1'b0);
		drive(1'b1);
	endtask
	// Frame in, sampled mid-bit
	initial forever begin
		@(negedge TXD);
		repeat (BIT_CLKS / 2) @(posedge MCLK);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CLKS) @(posedge MCLK);
			shift_reg[i] = TXD;
		end
		repeat (BIT_CLKS) @(posedge MCLK);
		if (TXD === 1'b1)
			got_q.push_back(shift_reg);
	end
endmodule

// [ussfw_top_tb.sv]
// Purpose: Self-checking bench for the UART sample/status block
// Assumes: Sample code 0xC, so one bit is 4 ticks
// Notes:   Remote model drives receive frames and collects sent bytes
module ussfw_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Addresses and signals
	localparam int BIT_CLKS = 4 * int'(ussfw_pkg::SAMPLE_DIV);
	localparam logic [11:0] A_FMT  = {ussfw_pkg::IDX_LINE_FMT, 2'b00};
	localparam logic [11:0] A_SPEC = {ussfw_pkg::IDX_SPECIAL, 2'b00};
	localparam logic [11:0] A_SAMP = {ussfw_pkg::IDX_SAMPLE, 2'b00};
	localparam logic [11:0] A_GLOB = {ussfw_pkg::IDX_GLOBAL, 2'b00};
	localparam logic [11:0] A_RXLO = {ussfw_pkg::IDX_RXWIN_LO, 2'b00};
	localparam logic [11:0] A_RXHI = {ussfw_pkg::IDX_RXWIN_HI, 2'b00};
	localparam logic [11:0] A_LSHI = {ussfw_pkg::IDX_LSWIN_HI, 2'b00};
	logic        MCLK    = 1'b0;
	logic        RST_B   = 1'b0;
	logic        PSEL    = 1'b0;
	logic        PENABLE = 1'b0;
	logic        PWRITE  = 1'b0;
	logic [11:0] PADDR   = 12'h000;
	logic [31:0] PWDATA  = 32'h0;
	logic [31:0] PRDATA;
	logic        PREADY;
	logic        PSLVERR;
	logic        RXD;
	logic        TXD;
	int          num_errors  = 0;
	int          check_count = 0;
	int          cycles      = 0;
	always #4 MCLK = ~MCLK;
	ussfw_top dut_u (.MCLK(MCLK), .RST_B(RST_B), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RXD(RXD),
		.TXD(TXD));
	ussfw_remote #(.BIT_CLKS(BIT_CLKS)) remote_u (.MCLK(MCLK), .TXD(TXD),
		.RXD(RXD));
	// ==========================================================
	// Shared tasks
	task automatic close_out;
		if (num_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge MCLK) begin
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			close_out();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		check_count++;
		if (seen !== want) begin
			num_errors++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, want);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic err);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		do @(posedge MCLK); while (PREADY !== 1'b1);
		q = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge MCLK);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] want);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		check(q, want);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset;
		logic [31:0] q;
		logic        e;
		rd_chk(A_SAMP, 32'h0);
		rd_chk(A_GLOB, 32'h60);
		rd_chk(A_RXLO, 32'h0);
		rd_chk(A_LSHI, 32'h0);
		apb(1'b0, 12'h080, 32'h0, q, e);
		check({31'h0, e}, 32'h1);
	endtask
	task automatic t_sample;
		wr(A_SAMP, 32'hFF);
		rd_chk(A_SAMP, 32'h0F);
		for (int n = 0; n < 16; n++) begin
			wr(A_SAMP, 32'(n));
			rd_chk(A_SAMP, 32'(n));
		end
		wr(A_SAMP, 32'hC);
		wr(A_SPEC, 32'h80);
		rd_chk(A_SAMP, 32'h0);
		wr(A_SAMP, 32'h3);
		wr(A_SPEC, 32'h0);
		rd_chk(A_SAMP, 32'hC);
	endtask
	task automatic t_tx;
		wr(A_RXLO, 32'hA5);
		wr(A_RXHI, 32'h3C);
		rd_chk(A_GLOB, 32'h00);
		wr(A_SPEC, 32'h80);
		rd_chk(A_SAMP, 32'h1);
		wr(A_SPEC, 32'h0);
		for (int i = 0; i < 8000 && remote_u.got_q.size() < 2; i++)
			@(posedge MCLK);
		check(32'(remote_u.got_q.size()), 32'h2);
		check({24'h0, remote_u.got_q[0]}, 32'hA5);
		check({24'h0, remote_u.got_q[1]}, 32'h3C);
		repeat (BIT_CLKS) @(posedge MCLK);
		rd_chk(A_GLOB, 32'h60);
	endtask
	task automatic rx_case(input logic [7:0] d, input logic par,
		input logic flip, input logic stop, input logic [7:0] glob,
		input logic [7:0] ls);
		remote_u.send(d, par, flip, stop);
		repeat (8) @(posedge MCLK);
		rd_chk(A_GLOB, {24'h0, glob});
		rd_chk(A_LSHI, {24'h0, ls});
		rd_chk(A_RXHI, {24'h0, d});
		rd_chk(A_GLOB, 32'h60);
	endtask
	task automatic t_rx;
		rx_case(8'h5A, 1'b0, 1'b0, 1'b1, 8'h61, 8'h00);
		wr(A_FMT, 32'h1);
		rx_case(8'hC3, 1'b1, 1'b1, 1'b1, 8'hE5, 8'h84);
		rx_case(8'h7E, 1'b1, 1'b0, 1'b0, 8'hE9, 8'h88);
		rx_case(8'h00, 1'b1, 1'b0, 1'b0, 8'hF1, 8'h90);
		rd_chk(A_RXLO, 32'h0);
	endtask
	initial begin
		repeat (2) @(posedge MCLK);
		RST_B <= 1'b1;
		@(posedge MCLK);
		t_reset();
		t_sample();
		t_tx();
		t_rx();
		close_out();
	end
endmodule
